/* File: logic/aiste_defines.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef AISTE_DEFINES_SVH
`define AISTE_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define AISTE_CTRL_OFS      8'h00
`define AISTE_SRC_OFS       8'h04
`define AISTE_DIV_OFS       8'h08
`define AISTE_DELAY_OFS     8'h0c
`define AISTE_PRE_OFS       8'h10
`define AISTE_POST_OFS      8'h14
`define AISTE_NCONV_OFS     8'h18
`define AISTE_STATUS_OFS    8'h1c
`define AISTE_COUNT_OFS     8'h20
`define AISTE_CMD_OFS       8'h24

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define AISTE_CTRL_TICK_FALL    0
`define AISTE_CTRL_BASE_FALL    1
`define AISTE_CTRL_PRETRIG      2
`define AISTE_CTRL_CONTINUOUS   3
`define AISTE_CTRL_SW_START     4
`define AISTE_CTRL_LEVEL_OUT    5
`define AISTE_CTRL_EXT_TICK     6

// ----------------------------------------------------------------------
// Command fields (write one to act)
// ----------------------------------------------------------------------
`define AISTE_CMD_START     0
`define AISTE_CMD_STOP      1
`define AISTE_CMD_SW_TICK   2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AISTE_DIV_RST       32'h0000_0014
`define AISTE_DELAY_RST     32'h0000_0002
`define AISTE_NCONV_RST     8'h01
`define AISTE_SRC_RST       32'h0000_0000
`define AISTE_PULSE_CYC     2

`endif

/* File: logic/aiste_pkg.sv */
// Types shared by the sample timing engine
package aiste_pkg;
	typedef enum logic [2:0] {
		AISTE_IDLE    = 3'b000,
		AISTE_DELAY   = 3'b001,
		AISTE_WAIT    = 3'b010,
		AISTE_CONVERT = 3'b011
	} aiste_state_t;

	typedef enum logic [1:0] {
		AISTE_INT_COUNTER = 2'b00,
		AISTE_INT_DIVIDED = 2'b01,
		AISTE_INT_SW      = 2'b10
	} aiste_int_src_t;
endpackage

/* File: logic/aiste_src_sel.sv */
// Source selectors and edge detectors for the timebase and external tick
`timescale 1ns/1ns
`include "aiste_defines.svh"
module aiste_src_sel (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [2:0]  base_sel,
	input  wire logic        base_fall,
	input  wire logic [3:0]  ext_sel,
	input  wire logic        tick_fall,
	input  wire logic        ref_20mhz,
	input  wire logic        ref_100khz,
	input  wire logic        backplane_10mhz_clock,
	input  wire logic [5:0]  function_terminal_in,
	input  wire logic [7:0]  sync_bus_line_in,
	input  wire logic        backplane_star_line,
	input  wire logic [2:0]  base_line_sel,
	output logic             base_edge,
	output logic             ext_edge
);
	logic base_lvl;
	logic ext_lvl;
	logic base_r;
	logic ext_r;

	// ------------------------------------------------------------------
	// Timebase mux: six choices; line index picks bus or terminal
	// ------------------------------------------------------------------
	always_comb begin
		unique case (base_sel)
			3'h0:    base_lvl = ref_20mhz;
			3'h1:    base_lvl = ref_100khz;
			3'h2:    base_lvl = backplane_10mhz_clock;
			3'h3:    base_lvl = sync_bus_line_in[base_line_sel];
			3'h4:    base_lvl = (base_line_sel < 3'h6) ?
				function_terminal_in[base_line_sel] : 1'b0;
			3'h5:    base_lvl = backplane_star_line;
			default: base_lvl = 1'b0;
		endcase
	end

	// External tick: 0..5 terminals, 6..13 bus lines, 14 star line
	always_comb begin
		if (ext_sel < 4'h6)
			ext_lvl = function_terminal_in[ext_sel[2:0]];
		else if (ext_sel < 4'he)
			ext_lvl = sync_bus_line_in[3'(ext_sel - 4'h6)];
		else if (ext_sel == 4'he)
			ext_lvl = backplane_star_line;
		else
			ext_lvl = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_r <= 1'b0;
			ext_r  <= 1'b0;
		end else begin
			base_r <= base_lvl;
			ext_r  <= ext_lvl;
		end
	end

	// Edge polarity selection
	assign base_edge = base_fall ? (base_r & ~base_lvl) :
		(~base_r & base_lvl);
	assign ext_edge  = tick_fall ? (ext_r & ~ext_lvl) :
		(~ext_r & ext_lvl);
endmodule // aiste_src_sel

/* File: logic/aiste_top.sv */
// Analog-input sample timing engine with AXI4-Lite registers
// Summary of operation
// - Internal tick in divided mode comes from a programmable divider on the tick base.
// - Each accepted tick samples every channel in the list once.
// - Sample starts on rising or falling external tick edge, software chosen.
// - Internal tick source: counter output, divided base, or software pulse.
// - External tick from input terminals 0-5, bus lines 0-7, star line.
// - Tick routes active high to output terminals 6-9 or bus lines.
// - Routed tick is a brief pulse or high for the whole sample.
// - Terminals 0-5 are inputs only, 6-9 outputs only.
// - Ticks are ignored while no acquisition runs.
// - Ticks are ignored while the pause gate is asserted.
// - Start starts the internal divider; it stops when finite run ends.
// - Delay from start to first internal tick, default two base periods.
// - Post-trigger: load post count, decrement per tick, end at zero.
// - Pre-trigger: load pre count, count down, then reload post count.
// - Early reference triggers are ignored; after one, finish post count.
// - Software start emits a pulse on the start trigger line.
// - Tick base from six sources including 20 MHz and 100 kHz.
// - Tick base active edge is rising or falling, software chosen.
// - The tick base is never driven to a terminal.
// - Sample and conversion ticks are ignored until a valid start.
// - After a tick, further ticks wait for all conversion ticks.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "aiste_defines.svh"
module aiste_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ref_20mhz,
	input  wire logic        ref_100khz,
	input  wire logic        backplane_10mhz_clock,
	input  wire logic        backplane_star_line,
	input  wire logic [5:0]  function_terminal_in,
	input  wire logic [7:0]  sync_bus_line_in,
	input  wire logic        counter_out,
	input  wire logic        hw_start_trigger,
	input  wire logic        stop_reference_trigger,
	input  wire logic        pause_gate,
	input  wire logic        conversion_tick,
	output logic [3:0]       function_terminal_out,
	output logic [7:0]       sync_bus_line_out,
	output logic [7:0]       sync_bus_line_oe,
	output logic             acquisition_start_trigger,
	output logic             sample_tick,
	output logic             acq_active,
	output logic             acq_done
);
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic [31:0] src_r;
	logic [31:0] div_r;
	logic [31:0] delay_r;
	logic [31:0] pre_r;
	logic [31:0] post_r;
	logic [7:0]  nconv_r;
	logic [31:0] count_r;
	logic        pre_phase_r;
	logic        ref_armed_r;
	logic        ref_seen_r;
	logic        done_r;
	logic [31:0] divcnt_r;
	logic [31:0] dlycnt_r;
	logic [7:0]  convcnt_r;
	logic [1:0]  pulse_r;
	logic        cntr_prev_r;
	aiste_pkg::aiste_state_t state_r;

	// AXI bus state
	logic        aw_held_r;
	logic        w_held_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;

	logic base_edge;
	logic ext_edge;
	logic int_tick;
	logic raw_tick;
	logic accept;
	logic wr_go;
	logic cmd_start;
	logic cmd_stop;
	logic cmd_sw_tick;
	logic start_evt;
	logic finish;
	logic conv_ok;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	function automatic logic [31:0] dec(input logic [31:0] v);
		return (v == 32'h0) ? 32'h0 : v - 32'h1;
	endfunction

	// ------------------------------------------------------------------
	// Source selection (tick base never leaves the block)
	// ------------------------------------------------------------------
	aiste_src_sel u_src (
		.aclk                  (aclk),
		.aresetn               (aresetn),
		.base_sel              (src_r[2:0]),
		.base_fall             (ctrl_r[`AISTE_CTRL_BASE_FALL]),
		.ext_sel               (src_r[7:4]),
		.tick_fall             (ctrl_r[`AISTE_CTRL_TICK_FALL]),
		.ref_20mhz             (ref_20mhz),
		.ref_100khz            (ref_100khz),
		.backplane_10mhz_clock (backplane_10mhz_clock),
		.function_terminal_in  (function_terminal_in),
		.sync_bus_line_in      (sync_bus_line_in),
		.backplane_star_line   (backplane_star_line),
		.base_line_sel         (src_r[18:16]),
		.base_edge             (base_edge),
		.ext_edge              (ext_edge)
	);

	// ------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_go = aw_held_r && w_held_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	assign s_axi_bresp = 2'b00;

	assign cmd_start   = wr_go && awaddr_r == `AISTE_CMD_OFS &&
		wstrb_r[0] && wdata_r[`AISTE_CMD_START];
	assign cmd_stop    = wr_go && awaddr_r == `AISTE_CMD_OFS &&
		wstrb_r[0] && wdata_r[`AISTE_CMD_STOP];
	assign cmd_sw_tick = wr_go && awaddr_r == `AISTE_CMD_OFS &&
		wstrb_r[0] && wdata_r[`AISTE_CMD_SW_TICK];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r  <= 32'h0;
			src_r   <= `AISTE_SRC_RST;
			div_r   <= `AISTE_DIV_RST;
			delay_r <= `AISTE_DELAY_RST;
			pre_r   <= 32'h0;
			post_r  <= 32'h0;
			nconv_r <= `AISTE_NCONV_RST;
		end else if (wr_go) begin
			unique case (awaddr_r)
				`AISTE_CTRL_OFS:  ctrl_r  <= merge(ctrl_r, wdata_r, wstrb_r);
				`AISTE_SRC_OFS:   src_r   <= merge(src_r, wdata_r, wstrb_r);
				`AISTE_DIV_OFS:   div_r   <= merge(div_r, wdata_r, wstrb_r);
				`AISTE_DELAY_OFS: delay_r <= merge(delay_r, wdata_r, wstrb_r);
				`AISTE_PRE_OFS:   pre_r   <= merge(pre_r, wdata_r, wstrb_r);
				`AISTE_POST_OFS:  post_r  <= merge(post_r, wdata_r, wstrb_r);
				`AISTE_NCONV_OFS: if (wstrb_r[0]) nconv_r <= wdata_r[7:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp   = 2'b00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			unique case (s_axi_araddr)
				`AISTE_CTRL_OFS:   s_axi_rdata <= ctrl_r;
				`AISTE_SRC_OFS:    s_axi_rdata <= src_r;
				`AISTE_DIV_OFS:    s_axi_rdata <= div_r;
				`AISTE_DELAY_OFS:  s_axi_rdata <= delay_r;
				`AISTE_PRE_OFS:    s_axi_rdata <= pre_r;
				`AISTE_POST_OFS:   s_axi_rdata <= post_r;
				`AISTE_NCONV_OFS:  s_axi_rdata <= {24'h0, nconv_r};
				`AISTE_STATUS_OFS: s_axi_rdata <= {25'h0, state_r,
					ref_seen_r, ref_armed_r, pre_phase_r, done_r};
				`AISTE_COUNT_OFS:  s_axi_rdata <= count_r;
				default:           s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Tick generation and gating
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cntr_prev_r <= 1'b0;
		else
			cntr_prev_r <= counter_out;
	end

	// Internal divider runs only after the start delay
	always_ff @(posedge aclk) begin
		if (!aresetn)
			divcnt_r <= 32'h0;
		else if (state_r == aiste_pkg::AISTE_IDLE ||
			state_r == aiste_pkg::AISTE_DELAY)
			divcnt_r <= 32'h0;
		else if (base_edge)
			divcnt_r <= (divcnt_r + 32'h1 >= div_r) ? 32'h0 :
				divcnt_r + 32'h1;
	end

	always_comb begin
		unique case (aiste_pkg::aiste_int_src_t'(src_r[9:8]))
			aiste_pkg::AISTE_INT_COUNTER:
				int_tick = counter_out & ~cntr_prev_r;
			aiste_pkg::AISTE_INT_DIVIDED:
				int_tick = base_edge && divcnt_r == 32'h0;
			aiste_pkg::AISTE_INT_SW:
				int_tick = cmd_sw_tick;
			default: int_tick = 1'b0;
		endcase
	end

	assign raw_tick = ctrl_r[`AISTE_CTRL_EXT_TICK] ? ext_edge : int_tick;
	// Ticks only count while waiting; busy converting masks them
	assign accept = raw_tick && state_r == aiste_pkg::AISTE_WAIT &&
		!pause_gate;
	assign conv_ok = conversion_tick &&
		state_r == aiste_pkg::AISTE_CONVERT;

	assign start_evt = state_r == aiste_pkg::AISTE_IDLE &&
		(ctrl_r[`AISTE_CTRL_SW_START] ? cmd_start : hw_start_trigger);

	// ------------------------------------------------------------------
	// Acquisition state machine
	// ------------------------------------------------------------------
	assign finish = !ctrl_r[`AISTE_CTRL_CONTINUOUS] && !pre_phase_r &&
		count_r == 32'h0 && (!ctrl_r[`AISTE_CTRL_PRETRIG] || ref_seen_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r   <= aiste_pkg::AISTE_IDLE;
			dlycnt_r  <= 32'h0;
			convcnt_r <= 8'h00;
		end else if (cmd_stop) begin
			state_r <= aiste_pkg::AISTE_IDLE;
		end else begin
			unique case (state_r)
				aiste_pkg::AISTE_IDLE:
					if (start_evt) begin
						dlycnt_r <= delay_r;
						state_r  <= ctrl_r[`AISTE_CTRL_EXT_TICK] ?
							aiste_pkg::AISTE_WAIT : aiste_pkg::AISTE_DELAY;
					end
				aiste_pkg::AISTE_DELAY:
					if (dlycnt_r <= 32'h1 && (base_edge || dlycnt_r == 32'h0))
						state_r <= aiste_pkg::AISTE_WAIT;
					else if (base_edge)
						dlycnt_r <= dlycnt_r - 32'h1;
				aiste_pkg::AISTE_WAIT:
					if (accept) begin
						convcnt_r <= nconv_r;
						state_r   <= aiste_pkg::AISTE_CONVERT;
					end
				aiste_pkg::AISTE_CONVERT:
					if (convcnt_r <= 8'h1 && (conv_ok || convcnt_r == 8'h0))
						state_r <= finish ? aiste_pkg::AISTE_IDLE :
							aiste_pkg::AISTE_WAIT;
					else if (conv_ok)
						convcnt_r <= convcnt_r - 8'h1;
				default: state_r <= aiste_pkg::AISTE_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Sample counter, pre/post phases, reference trigger
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r     <= 32'h0;
			pre_phase_r <= 1'b0;
			ref_armed_r <= 1'b0;
			ref_seen_r  <= 1'b0;
		end else if (start_evt) begin
			pre_phase_r <= ctrl_r[`AISTE_CTRL_PRETRIG];
			ref_armed_r <= 1'b0;
			ref_seen_r  <= 1'b0;
			count_r     <= ctrl_r[`AISTE_CTRL_PRETRIG] ? pre_r :
				post_r;
		end else begin
			if (accept) begin
				if (pre_phase_r && dec(count_r) == 32'h0) begin
					pre_phase_r <= 1'b0;
					ref_armed_r <= 1'b1;
					count_r     <= post_r;
				end else if (!ctrl_r[`AISTE_CTRL_PRETRIG] || pre_phase_r ||
					ref_seen_r)
					count_r <= dec(count_r);
			end
			if (stop_reference_trigger && ref_armed_r && !ref_seen_r)
				ref_seen_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			done_r <= 1'b0;
		else if (start_evt)
			done_r <= 1'b0;
		else if (state_r == aiste_pkg::AISTE_CONVERT && finish)
			done_r <= 1'b1;
	end

	// ------------------------------------------------------------------
	// Output routing of the tick and software start pulse
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pulse_r <= 2'h0;
		else if (accept)
			pulse_r <= 2'(`AISTE_PULSE_CYC);
		else if (pulse_r != 2'h0)
			pulse_r <= pulse_r - 2'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sample_tick               <= 1'b0;
			acquisition_start_trigger <= 1'b0;
			function_terminal_out     <= 4'h0;
			sync_bus_line_out         <= 8'h00;
			sync_bus_line_oe          <= 8'h00;
		end else begin
			sample_tick <= ctrl_r[`AISTE_CTRL_LEVEL_OUT] ?
				(accept || state_r == aiste_pkg::AISTE_CONVERT) :
				(accept || pulse_r != 2'h0);
			acquisition_start_trigger <= start_evt &&
				ctrl_r[`AISTE_CTRL_SW_START];
			// Active high routing; terminals 6..9 are outputs only
			function_terminal_out <= src_r[23:20] & {4{ctrl_r[
				`AISTE_CTRL_LEVEL_OUT] ? (accept || state_r ==
				aiste_pkg::AISTE_CONVERT) : (accept || pulse_r != 2'h0)}};
			sync_bus_line_out <= src_r[31:24] & {8{ctrl_r[
				`AISTE_CTRL_LEVEL_OUT] ? (accept || state_r ==
				aiste_pkg::AISTE_CONVERT) : (accept || pulse_r != 2'h0)}};
			sync_bus_line_oe <= src_r[31:24];
		end
	end

	assign acq_active = state_r != aiste_pkg::AISTE_IDLE;
	assign acq_done   = done_r;
endmodule // aiste_top

/* File: tb/aiste_assertions.sv */
// Port checker for the sample timing engine
`timescale 1ns/1ns
module aiste_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_arready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        pause_gate,
	input wire logic [3:0]  function_terminal_out,
	input wire logic        acquisition_start_trigger,
	input wire logic        sample_tick,
	input wire logic        acq_active,
	input wire logic        acq_done
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_tick_active: assert property ($rose(sample_tick) |-> $past(acq_active))
		else $error("sample tick outside acquisition");
	a_tick_pause: assert property (pause_gate [*3] |=> !$rose(sample_tick))
		else $error("sample tick while paused");
	a_done_ends: assert property ($rose(acq_done) |-> $past(acq_active))
		else $error("done without a running acquisition");
	a_start_pulse: assert property (acquisition_start_trigger |=>
		!acquisition_start_trigger)
		else $error("start pulse longer than one cycle");
	a_route_tick: assert property (|function_terminal_out |->
		sample_tick)
		else $error("terminal high without sample tick");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && s_axi_bresp == 2'h0)
		else $error("write response dropped");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready
		&& s_axi_rresp == 2'h0)
		else $error("read address taken while answering");
endmodule // aiste_assertions

bind aiste_top aiste_assertions u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_arready(s_axi_arready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pause_gate(pause_gate),
	.function_terminal_out(function_terminal_out),
	.acquisition_start_trigger(acquisition_start_trigger),
	.sample_tick(sample_tick), .acq_active(acq_active),
	.acq_done(acq_done)
);

/* File: tb/aiste_far_side.sv */
// Far-side model: timebase references and the converter's ticks
`timescale 1ns/1ns
module aiste_far_side #(
	parameter int NCONV = 2
) (
	input  wire logic       aclk,
	input  wire logic       sample_tick,
	input  wire logic [3:0] gap,
	output logic            conversion_tick,
	output logic            backplane_10mhz_clock,
	output logic            ref_20mhz,
	output logic            ref_100khz
);
	initial begin
		conversion_tick = 1'h0;
		backplane_10mhz_clock = 1'h0;
		ref_20mhz = 1'h0;
		ref_100khz = 1'h0;
	end
	// Non-blocking so edges that meet aclk are seen after that edge
	always #50 backplane_10mhz_clock <= ~backplane_10mhz_clock;
	always #25 ref_20mhz <= ~ref_20mhz;
	always #5000 ref_100khz <= ~ref_100khz;
	// Answer each sample with NCONV conversions, the first after gap cycles, then every gap+2 cycles
	always begin
		@(posedge sample_tick);
		repeat (NCONV) begin
			repeat (gap) @(posedge aclk);
			conversion_tick <= 1'h1;
			@(posedge aclk);
			conversion_tick <= 1'h0;
			@(posedge aclk);
		end
	end
endmodule // aiste_far_side

/* File: tb/testbench.sv */
// Self-checking bench for the sample timing engine
`timescale 1ns/1ns
`include "aiste_defines.svh"
module testbench;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, cnt_out;
	logic        ref_trig, pause, conv, r20, r100k, c10, st, tick, tick_d;
	logic        active, done;
	logic [7:0]  awaddr, araddr, bus_out, bus_oe;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [5:0]  ft_in;
	logic [3:0]  ft_out, gap;
	int          error_cnt, n_compared, ntick, cyc, nst, nft;

	aiste_top uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ref_20mhz(r20), .ref_100khz(r100k),
		.backplane_10mhz_clock(c10), .backplane_star_line(1'h0),
		.function_terminal_in(ft_in), .sync_bus_line_in(8'h00),
		.counter_out(cnt_out), .hw_start_trigger(1'h0),
		.stop_reference_trigger(ref_trig), .pause_gate(pause),
		.conversion_tick(conv), .function_terminal_out(ft_out),
		.sync_bus_line_out(bus_out), .sync_bus_line_oe(bus_oe),
		.acquisition_start_trigger(st), .sample_tick(tick),
		.acq_active(active), .acq_done(done)
	);
	aiste_far_side far (
		.aclk(aclk), .sample_tick(tick), .gap(gap),
		.conversion_tick(conv), .backplane_10mhz_clock(c10),
		.ref_20mhz(r20), .ref_100khz(r100k)
	);

	always #20 aclk = ~aclk;
	// Event counts and run limit, taken where outputs are settled
	always @(negedge aclk) begin
		if (tick && !tick_d) ntick++;
		tick_d = tick;
		if (st) nst++;
		if (ft_out[0] && bus_out[0]) nft++;
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic da, dw;
		da = 1'h0;
		dw = 1'h0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(da && dw)) begin
			@(negedge aclk);
			da = da || (awvalid && awready);
			dw = dw || (wvalid && wready);
			@(posedge aclk);
			if (da) awvalid <= 1'h0;
			if (dw) wvalid <= 1'h0;
		end
		bready <= 1'h1;
		do @(negedge aclk); while (bvalid !== 1'h1);
		@(posedge aclk);
		bready <= 1'h0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		araddr <= a;
		arvalid <= 1'h1;
		do @(negedge aclk); while (arready !== 1'h1);
		@(posedge aclk);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(negedge aclk); while (rvalid !== 1'h1);
		chk(rdata, e);
		@(posedge aclk);
		rready <= 1'h0;
	endtask

	task automatic wait_ticks(input int n);
		for (int i = 0; i < 3000 && ntick < n; i++) @(posedge aclk);
	endtask

	task automatic wait_done();
		for (int i = 0; i < 3000 && done !== 1'h1; i++) @(posedge aclk);
		chk({31'h0, done}, 32'h1);
	endtask

	task automatic start(input logic [31:0] ctrl, input logic [31:0] src);
		wr(`AISTE_CTRL_OFS, ctrl);
		wr(`AISTE_SRC_OFS, src);
		ntick = 0;
		wr(`AISTE_CMD_OFS, 32'h1);
	endtask

	task automatic t_reset();
		rc(`AISTE_DIV_OFS, `AISTE_DIV_RST);
		rc(`AISTE_DELAY_OFS, `AISTE_DELAY_RST);
		rc(`AISTE_NCONV_OFS, {24'h0, `AISTE_NCONV_RST});
		rc(`AISTE_STATUS_OFS, 32'h0);
		rc(8'h40, 32'h0);
	endtask

	task automatic t_post();
		wr(`AISTE_DIV_OFS, 32'h4);
		wr(`AISTE_NCONV_OFS, 32'h2);
		wr(`AISTE_POST_OFS, 32'h3);
		nst = 0;
		nft = 0;
		start(32'h10, 32'h0110_0102);
		chk(nst, 1);
		chk({24'h0, bus_oe}, 32'h1);
		wait_done();
		chk(ntick, 3);
		repeat (40) @(posedge aclk);
		chk(ntick, 3);
		chk(nft != 0, 1);
	endtask

	task automatic t_pre();
		wr(`AISTE_PRE_OFS, 32'h2);
		wr(`AISTE_POST_OFS, 32'h2);
		start(32'h14, 32'h0000_0102);
		ref_trig <= 1'h1;
		@(posedge aclk);
		ref_trig <= 1'h0;
		wait_ticks(5);
		chk({31'h0, done}, 32'h0);
		ntick = 0;
		wait_ticks(1);
		repeat (3) @(posedge aclk);
		ref_trig <= 1'h1;
		ntick = 0;
		@(posedge aclk);
		ref_trig <= 1'h0;
		wait_done();
		chk(ntick, 2);
	endtask

	task automatic t_pause();
		gap <= 4'h3;
		start(32'h18, 32'h0000_0102);
		wait_ticks(1);
		pause <= 1'h1;
		repeat (3) @(posedge aclk);
		ntick = 0;
		repeat (60) @(posedge aclk);
		chk(ntick, 0);
		pause <= 1'h0;
		wait_ticks(1);
		chk(ntick, 1);
		wr(`AISTE_CMD_OFS, 32'h2);
		chk({31'h0, active}, 32'h0);
		ntick = 0;
		repeat (60) @(posedge aclk);
		chk(ntick, 0);
	endtask

	task automatic t_src();
		wr(`AISTE_POST_OFS, 32'h1);
		for (int k = 0; k < 3; k += 2) begin
			start(32'h12, (k << 8) | 32'h2);
			repeat (30) @(posedge aclk);
			if (k == 0) begin
				cnt_out <= 1'h1;
				repeat (3) @(posedge aclk);
				cnt_out <= 1'h0;
			end else begin
				wr(`AISTE_CMD_OFS, 32'h4);
			end
			wait_done();
			chk(ntick, 1);
		end
	endtask

	task automatic t_ext();
		gap <= 4'h6;
		wr(`AISTE_POST_OFS, 32'h2);
		start(32'h71, 32'h0);
		repeat (10) @(posedge aclk);
		for (int i = 0; i < 2; i++) begin
			ft_in[0] <= 1'h1;
			repeat (6) @(posedge aclk);
			chk(ntick, i);
			ft_in[0] <= 1'h0;
			repeat (8) @(posedge aclk);
			chk({31'h0, tick}, 32'h1);
			repeat (30) @(posedge aclk);
			chk(ntick, i + 1);
		end
		wait_done();
	endtask

	task automatic stop_test();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{cnt_out, ref_trig, pause, tick_d} = 4'h0;
		{awaddr, araddr, wdata, ft_in} = 54'h0;
		gap = 4'h0;
		{error_cnt, n_compared, ntick, cyc, nst, nft} = 192'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset();
		t_post();
		t_pre();
		t_pause();
		t_src();
		t_ext();
		stop_test();
	end
endmodule // testbench
